// File: verilog/cc_detect_pkg.sv
// package of constants and types for the configuration-line attach detector
package cc_detect_pkg;
	// role selection
	typedef enum logic [1:0] {ROLE_SOURCE = 2'h0, ROLE_SINK = 2'h1, ROLE_DUAL = 2'h2} role_t;
	// advertisement levels
	localparam logic [1:0] ADV_DEF500 = 2'h0;
	localparam logic [1:0] ADV_DEF900 = 2'h1;
	localparam logic [1:0] ADV_1A5 = 2'h2;
	localparam logic [1:0] ADV_3A0 = 2'h3;
	// line classification codes
	typedef enum logic [1:0] {LINE_OPEN = 2'h0, LINE_SINK = 2'h1, LINE_CABLE = 2'h2} line_t;
	// connection states, gray along open -> attached -> swap
	typedef enum logic [2:0] {
		ST_OPEN = 3'h0, ST_CABLE = 3'h1, ST_SINK = 3'h3, ST_CABLE_SINK = 3'h2,
		ST_DEBUG = 3'h6, ST_AUDIO = 3'h7, ST_SRC_SEEN = 3'h5, ST_SWAP = 3'h4
	} conn_t;
	// timing
	localparam int CLK_HZ = 25000000;
	localparam int DEBOUNCE_US = 100;
	localparam int DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1000000);
	localparam int TOGGLE_US = 50;
	localparam int TOGGLE_CYC = TOGGLE_US * (CLK_HZ / 1000000);
	// reset values
	localparam logic [1:0] ADV_RESET = ADV_DEF500;
	localparam logic [7:0] STRAP_RESET = 8'h00;
	// strap code at or above this selects the wait-for-external-supply start-up
	localparam logic [7:0] STRAP_WAIT_EXT = 8'hC0;
endpackage : cc_detect_pkg

// File: verilog/line_debounce.sv
// debounce of one line classification
`timescale 1ns/1ps
module line_debounce
	import cc_detect_pkg::*;
#(
	parameter int CYCLES = DEBOUNCE_CYC
)(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic [1:0] raw,
	output logic [1:0] stable
);
	initial if (CYCLES < 2 || CYCLES > 65535) $error("line_debounce: CYCLES out of range");
	logic [1:0] last_reg;
	logic [15:0] count_reg;
	// a change must hold for CYCLES before it is passed on
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			last_reg <= 2'h0;
			count_reg <= 16'h0000;
			stable <= 2'h0;
		end
		else if (clk_en)
		begin
			last_reg <= raw;
			if (raw != last_reg)
				count_reg <= 16'h0000;
			else if (count_reg == 16'(CYCLES - 1))
				stable <= raw;
			else
				count_reg <= count_reg + 16'h0001;
		end
	end
	stable_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
		(clk_en && raw != last_reg) |=> $stable(stable))
		else $error("debounced line changed on an unsettled input");
endmodule : line_debounce

// File: verilog/line_classify.sv
// threshold comparison of one line against the selected advertisement level
`timescale 1ns/1ps
module line_classify
	import cc_detect_pkg::*;
(
	input wire logic [1:0] adv_level,
	input wire logic [7:0] line_mv8,
	input wire logic [7:0] sink_thr_0,
	input wire logic [7:0] sink_thr_1,
	input wire logic [7:0] sink_thr_2,
	input wire logic [7:0] sink_thr_3,
	input wire logic [7:0] cable_thr_0,
	input wire logic [7:0] cable_thr_1,
	input wire logic [7:0] cable_thr_2,
	input wire logic [7:0] cable_thr_3,
	output logic [1:0] klass
);
	logic [7:0] sink_thr;
	logic [7:0] cable_thr;
	// thresholds follow the advertisement level
	always_comb
	begin
		unique case (adv_level)
			ADV_DEF500: begin sink_thr = sink_thr_0; cable_thr = cable_thr_0; end
			ADV_DEF900: begin sink_thr = sink_thr_1; cable_thr = cable_thr_1; end
			ADV_1A5: begin sink_thr = sink_thr_2; cable_thr = cable_thr_2; end
			default: begin sink_thr = sink_thr_3; cable_thr = cable_thr_3; end
		endcase
		if (line_mv8 < cable_thr)
			klass = LINE_CABLE;
		else if (line_mv8 < sink_thr)
			klass = LINE_SINK;
		else
			klass = LINE_OPEN;
	end
endmodule : line_classify

// File: verilog/cc_attach_port.sv
// attach, orientation, role and swap logic for one Type-C port
`timescale 1ns/1ps
module cc_attach_port
	import cc_detect_pkg::*;
#(
	parameter int DEB_CYCLES = DEBOUNCE_CYC,
	parameter int TOG_CYCLES = TOGGLE_CYC
)(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic [1:0] role_sel,
	input wire logic [1:0] adv_level,
	input wire logic swap_enable,
	input wire logic swap_request,
	input wire logic [7:0] cc1_level,
	input wire logic [7:0] cc2_level,
	input wire logic [7:0] sink_thr_0,
	input wire logic [7:0] sink_thr_1,
	input wire logic [7:0] sink_thr_2,
	input wire logic [7:0] sink_thr_3,
	input wire logic [7:0] cable_thr_0,
	input wire logic [7:0] cable_thr_1,
	input wire logic [7:0] cable_thr_2,
	input wire logic [7:0] cable_thr_3,
	input wire logic [7:0] adv_rd_thr_0,
	input wire logic [7:0] adv_rd_thr_1,
	input wire logic [7:0] swap_thr,
	input wire logic vbus_present,
	input wire logic dead_battery,
	input wire logic ovp_uvp,
	input wire logic path_ctl_allow,
	output logic [2:0] conn_state,
	output logic flipped,
	output logic vbus_on,
	output logic vconn_cc1_on,
	output logic vconn_cc2_on,
	output logic pullup_on,
	output logic [1:0] pullup_level,
	output logic pulldown_on,
	output logic deadbat_gate_oe,
	output logic swap_pulldown_cc1,
	output logic swap_pulldown_cc2,
	output logic swap_detected,
	output logic [1:0] partner_adv,
	output logic ext_path_ctl,
	output logic source_active
);
	initial if (TOG_CYCLES < 2 || TOG_CYCLES > 65535) $error("cc_attach_port: TOG_CYCLES bad");
	// pin levels arrive from the analog front end, outside the clock domain
	logic [7:0] cc1_s1_reg;
	logic [7:0] cc1_s2_reg;
	logic [7:0] cc2_s1_reg;
	logic [7:0] cc2_s2_reg;
	logic [1:0] vb_sync_reg;
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cc1_s1_reg <= 8'hFF;
			cc1_s2_reg <= 8'hFF;
			cc2_s1_reg <= 8'hFF;
			cc2_s2_reg <= 8'hFF;
			vb_sync_reg <= 2'h0;
		end
		else if (clk_en)
		begin
			cc1_s1_reg <= cc1_level;
			cc1_s2_reg <= cc1_s1_reg;
			cc2_s1_reg <= cc2_level;
			cc2_s2_reg <= cc2_s1_reg;
			vb_sync_reg <= {vb_sync_reg[0], vbus_present};
		end
	end
	wire vbus_sync = vb_sync_reg[1];
	// classify both lines, then debounce each
	logic [1:0] raw1;
	logic [1:0] raw2;
	logic [1:0] deb1;
	logic [1:0] deb2;
	line_classify cls1 (.adv_level(adv_level), .line_mv8(cc1_s2_reg),
		.sink_thr_0(sink_thr_0), .sink_thr_1(sink_thr_1), .sink_thr_2(sink_thr_2),
		.sink_thr_3(sink_thr_3), .cable_thr_0(cable_thr_0), .cable_thr_1(cable_thr_1),
		.cable_thr_2(cable_thr_2), .cable_thr_3(cable_thr_3), .klass(raw1));
	line_classify cls2 (.adv_level(adv_level), .line_mv8(cc2_s2_reg),
		.sink_thr_0(sink_thr_0), .sink_thr_1(sink_thr_1), .sink_thr_2(sink_thr_2),
		.sink_thr_3(sink_thr_3), .cable_thr_0(cable_thr_0), .cable_thr_1(cable_thr_1),
		.cable_thr_2(cable_thr_2), .cable_thr_3(cable_thr_3), .klass(raw2));
	line_debounce #(.CYCLES(DEB_CYCLES)) db1 (.clk(clk), .reset_n(reset_n),
		.clk_en(clk_en), .raw(raw1), .stable(deb1));
	line_debounce #(.CYCLES(DEB_CYCLES)) db2 (.clk(clk), .reset_n(reset_n),
		.clk_en(clk_en), .raw(raw2), .stable(deb2));

	// acting role: a swap flips it until the partner goes away
	logic act_source_reg;
	logic [15:0] tog_reg;
	conn_t state_reg;
	conn_t state_next;
	logic watch_cc2_reg;
	logic swapped_reg;
	// a swapped port keeps its new role, so it is not idle for the role select
	wire idle = (state_reg == ST_OPEN) && !swapped_reg;
	// dual role flips terminations only while nothing is attached
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			act_source_reg <= 1'b1;
			tog_reg <= 16'h0000;
		end
		else if (clk_en)
		begin
			if (state_reg == ST_SWAP && state_next != ST_SWAP)
				act_source_reg <= ~act_source_reg;
			else if (idle && role_t'(role_sel) == ROLE_SOURCE)
				act_source_reg <= 1'b1;
			else if (idle && role_t'(role_sel) == ROLE_SINK)
				act_source_reg <= 1'b0;
			else if (idle && role_t'(role_sel) == ROLE_DUAL)
			begin
				if (tog_reg == 16'(TOG_CYCLES - 1))
				begin
					tog_reg <= 16'h0000;
					act_source_reg <= ~act_source_reg;
				end
				else
					tog_reg <= tog_reg + 16'h0001;
			end
		end
	end

	// a swap holds the new role until the partner goes away, else the idle
	// role select would pull it straight back
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			swapped_reg <= 1'b0;
		else if (clk_en)
		begin
			if (state_reg == ST_SWAP && state_next != ST_SWAP)
				swapped_reg <= 1'b1;
			else if (state_reg != ST_OPEN && state_next == ST_OPEN)
				swapped_reg <= 1'b0;
		end
	end

	// sink side: source seen through VBUS, swap seen through a low line
	wire sink_line_low = (cc1_s2_reg < swap_thr && !watch_cc2_reg) ||
		(cc2_s2_reg < swap_thr && watch_cc2_reg);
	// source side: decode the termination pair
	always_comb
	begin
		state_next = state_reg;
		if (act_source_reg)
		begin
			unique case ({deb1, deb2})
				{LINE_OPEN, LINE_OPEN}: state_next = ST_OPEN;
				{LINE_SINK, LINE_OPEN}, {LINE_OPEN, LINE_SINK}: state_next = ST_SINK;
				{LINE_CABLE, LINE_OPEN}, {LINE_OPEN, LINE_CABLE}: state_next = ST_CABLE;
				{LINE_CABLE, LINE_SINK}, {LINE_SINK, LINE_CABLE}:
					state_next = ST_CABLE_SINK;
				{LINE_SINK, LINE_SINK}: state_next = ST_DEBUG;
				{LINE_CABLE, LINE_CABLE}: state_next = ST_AUDIO;
				default: state_next = ST_OPEN;
			endcase
			if (state_reg == ST_CABLE_SINK && (watch_cc2_reg ? deb2 : deb1) == LINE_SINK)
				state_next = ST_CABLE_SINK;
			if (swap_enable && swap_request &&
				(state_reg == ST_SINK || state_reg == ST_CABLE_SINK))
				state_next = ST_SWAP;
			if (state_reg == ST_SWAP)
				state_next = vbus_sync ? ST_SWAP : ST_OPEN;
		end
		else
		begin
			if (state_reg == ST_SWAP)
				state_next = ST_SWAP; // role flips on leaving
			else if (vbus_sync)
				state_next = ST_SRC_SEEN;
			else
				state_next = ST_OPEN;
			if (state_reg == ST_SRC_SEEN && swap_enable && sink_line_low)
				state_next = ST_SWAP;
			if (state_reg == ST_SWAP)
				state_next = ST_OPEN;
		end
	end
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			state_reg <= ST_OPEN;
		else if (clk_en)
			state_reg <= state_next;
	end
	// orientation: the line that holds the sink (or the pulled-up line when sinking)
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			watch_cc2_reg <= 1'b0;
		else if (clk_en && (state_reg == ST_OPEN || state_reg == ST_CABLE))
		begin
			if (act_source_reg)
				watch_cc2_reg <= (deb2 == LINE_SINK);
			else
				watch_cc2_reg <= (cc2_s2_reg > cc1_s2_reg);
		end
	end
	// partner advertisement decoded from the pull-up level while sinking
	logic [7:0] sink_line;
	assign sink_line = watch_cc2_reg ? cc2_s2_reg : cc1_s2_reg;
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			partner_adv <= ADV_DEF500;
		else if (clk_en && !act_source_reg && state_reg == ST_SRC_SEEN)
		begin
			if (sink_line >= adv_rd_thr_1)
				partner_adv <= ADV_3A0;
			else if (sink_line >= adv_rd_thr_0)
				partner_adv <= ADV_1A5;
			else
				partner_adv <= ADV_DEF500;
		end
	end
	// outputs from flip-flops; power only once a sink is present
	// path_ctl_allow carries the core's start-up choice from the strap reading
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			conn_state <= 3'h0;
			flipped <= 1'b0;
			vbus_on <= 1'b0;
			vconn_cc1_on <= 1'b0;
			vconn_cc2_on <= 1'b0;
			pullup_on <= 1'b0;
			pullup_level <= ADV_RESET;
			pulldown_on <= 1'b0;
			deadbat_gate_oe <= 1'b0;
			swap_pulldown_cc1 <= 1'b0;
			swap_pulldown_cc2 <= 1'b0;
			swap_detected <= 1'b0;
			ext_path_ctl <= 1'b0;
			source_active <= 1'b0;
		end
		else if (clk_en)
		begin
			conn_state <= state_next;
			flipped <= watch_cc2_reg;
			vbus_on <= act_source_reg && (state_next == ST_SINK ||
				state_next == ST_CABLE_SINK) && !ovp_uvp;
			vconn_cc1_on <= act_source_reg && state_next == ST_CABLE_SINK &&
				deb1 == LINE_CABLE;
			vconn_cc2_on <= act_source_reg && state_next == ST_CABLE_SINK &&
				deb2 == LINE_CABLE;
			pullup_on <= act_source_reg && !dead_battery;
			pullup_level <= adv_level;
			pulldown_on <= !act_source_reg && !dead_battery;
			deadbat_gate_oe <= !dead_battery;
			swap_pulldown_cc1 <= act_source_reg && state_next == ST_SWAP &&
				!watch_cc2_reg;
			swap_pulldown_cc2 <= act_source_reg && state_next == ST_SWAP &&
				watch_cc2_reg;
			swap_detected <= !act_source_reg && state_reg == ST_SRC_SEEN &&
				state_next == ST_SWAP;
			ext_path_ctl <= path_ctl_allow && !ovp_uvp && (act_source_reg ?
				(state_next == ST_SINK || state_next == ST_CABLE_SINK) :
				state_next == ST_SRC_SEEN);
			source_active <= act_source_reg;
		end
	end
	// assertions
	no_power_open_a: assert property (@(posedge clk) disable iff (!reset_n)
		clk_en && act_source_reg && state_reg == ST_OPEN && deb1 == LINE_OPEN &&
		deb2 == LINE_OPEN |=> !vbus_on && !vconn_cc1_on && !vconn_cc2_on)
		else $error("power applied with nothing attached");
	vconn_cable_only_a: assert property (@(posedge clk) disable iff (!reset_n)
		vconn_cc1_on |-> !vconn_cc2_on && conn_state == 3'(ST_CABLE_SINK))
		else $error("cable power outside a cable-plus-sink attach");
	vconn_cc2_only_a: assert property (@(posedge clk) disable iff (!reset_n)
		vconn_cc2_on |-> !vconn_cc1_on && conn_state == 3'(ST_CABLE_SINK))
		else $error("cable power outside a cable-plus-sink attach");
	cable_no_power_a: assert property (@(posedge clk) disable iff (!reset_n)
		conn_state == 3'(ST_CABLE) |-> !vbus_on && !vconn_cc1_on && !vconn_cc2_on)
		else $error("power applied with only a cable");
	deadbat_hiz_a: assert property (@(posedge clk) disable iff (!reset_n)
		clk_en && dead_battery |=> !deadbat_gate_oe && !pullup_on)
		else $error("gate driver active during dead battery");
	path_drop_a: assert property (@(posedge clk) disable iff (!reset_n)
		clk_en && ovp_uvp |=> !ext_path_ctl && !vbus_on)
		else $error("path control held through a fault");
	sink_attach_a: assert property (@(posedge clk) disable iff (!reset_n)
		clk_en && !act_source_reg && state_reg == ST_OPEN && vbus_sync |=>
		conn_state == 3'(ST_SRC_SEEN))
		else $error("vbus did not mark a source attach");
	swap_report_a: assert property (@(posedge clk) disable iff (!reset_n)
		swap_detected |-> $past(swap_enable) && !source_active)
		else $error("swap reported outside an enabled sink");
	terms_exclusive_a: assert property (@(posedge clk) disable iff (!reset_n)
		!(pullup_on && pulldown_on))
		else $error("pull-up and pull-down both applied");
	swap_one_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
		clk_en && swap_detected |=> !swap_detected)
		else $error("swap report longer than one cycle");
	swap_role_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
		(clk_en && swap_detected) ##1 clk_en ##1 clk_en ##1 clk_en |=> source_active)
		else $error("role fell back right after a sink-side swap");
	swap_pd_single_a: assert property (@(posedge clk) disable iff (!reset_n)
		swap_pulldown_cc1 || swap_pulldown_cc2 |-> source_active &&
		!(swap_pulldown_cc1 && swap_pulldown_cc2))
		else $error("swap pull-down outside sourcing or on both lines");
endmodule : cc_attach_port

// File: test/cc_partner_model.sv
// behavioural port partner: terminations, source pull-up and swap signal
`timescale 1ns/1ps
module cc_partner_model
	import cc_detect_pkg::*;
(
	input wire logic swap_pulldown_cc1,
	input wire logic swap_pulldown_cc2,
	input wire logic [1:0] term1,
	input wire logic [1:0] term2,
	input wire logic src_mode,
	input wire logic [7:0] src_code,
	input wire logic frs_low,
	output logic [7:0] cc1_level,
	output logic [7:0] cc2_level
);
	// line code under the device pull-up: 0 open, 1 sink, 2 cable, 3 weak sink
	function automatic logic [7:0] term_code(input logic [1:0] t);
		case (t)
			2'h1: term_code = 8'h50;
			2'h2: term_code = 8'h18;
			2'h3: term_code = 8'h70;
			default: term_code = 8'hFF;
		endcase
	endfunction : term_code
	// no data lines here: their pull-ups and pull-downs are the system's own
	// a partner source pulls cc1 up; its unused line sits at ground under our pull-down
	always_comb
	begin
		cc1_level = src_mode ? (frs_low ? 8'h08 : src_code) : term_code(term1);
		cc2_level = src_mode ? 8'h00 : term_code(term2);
		if (swap_pulldown_cc1)
			cc1_level = 8'h08;
		if (swap_pulldown_cc2)
			cc2_level = 8'h08;
	end
endmodule : cc_partner_model

// File: test/cc_attach_port_test.sv
// self-checking bench for the one-port attach detector
`timescale 1ns/1ps
module cc_attach_port_test;
	import cc_detect_pkg::*;
	localparam int DEB = 4;
	localparam int SETTLE = DEB + 8;
	logic clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1;
	logic [1:0] role_sel = 2'h0, adv_level = 2'h0;
	logic swap_enable = 1'b0, swap_request = 1'b0, vbus_present = 1'b0;
	logic dead_battery = 1'b0, ovp_uvp = 1'b0, path_ctl_allow = 1'b0;
	logic [7:0] sink_thr [4] = '{8'h60, 8'h80, 8'hA0, 8'hC0};
	logic [7:0] cable_thr [4] = '{8'h20, 8'h28, 8'h30, 8'h38};
	logic [7:0] rd_thr [2] = '{8'h80, 8'hC0};
	logic [7:0] swap_thr = 8'h10, src_code = 8'h40, cc1_level, cc2_level;
	logic [1:0] term1 = 2'h0, term2 = 2'h0, pullup_level, partner_adv;
	logic src_mode = 1'b0, frs_low = 1'b0;
	logic [2:0] conn_state;
	logic flipped, vbus_on, vconn_cc1_on, vconn_cc2_on, pullup_on, pulldown_on;
	logic deadbat_gate_oe, swap_pulldown_cc1, swap_pulldown_cc2, swap_detected;
	logic ext_path_ctl, source_active;
	int errors = 0, comparisons = 0;
	// rows: cc1 term, cc2 term, state, flipped, vbus, vconn cc1, vconn cc2
	logic [10:0] src_table [7] = '{{2'h1, 2'h0, 3'h3, 4'h4}, {2'h0, 2'h1, 3'h3, 4'hC},
		{2'h2, 2'h0, 3'h1, 4'h0}, {2'h2, 2'h1, 3'h2, 4'hE}, {2'h1, 2'h2, 3'h2, 4'h5},
		{2'h1, 2'h1, 3'h6, 4'h0}, {2'h2, 2'h2, 3'h7, 4'h0}};

	always #20 clk = ~clk;

	cc_attach_port #(.DEB_CYCLES(DEB), .TOG_CYCLES(8)) u_cc_attach_port (.clk(clk),
		.reset_n(reset_n), .clk_en(clk_en), .role_sel(role_sel), .adv_level(adv_level),
		.swap_enable(swap_enable), .swap_request(swap_request), .cc1_level(cc1_level),
		.cc2_level(cc2_level), .sink_thr_0(sink_thr[0]), .sink_thr_1(sink_thr[1]),
		.sink_thr_2(sink_thr[2]), .sink_thr_3(sink_thr[3]), .cable_thr_0(cable_thr[0]),
		.cable_thr_1(cable_thr[1]), .cable_thr_2(cable_thr[2]), .cable_thr_3(cable_thr[3]),
		.adv_rd_thr_0(rd_thr[0]), .adv_rd_thr_1(rd_thr[1]), .swap_thr(swap_thr),
		.vbus_present(vbus_present), .dead_battery(dead_battery), .ovp_uvp(ovp_uvp),
		.path_ctl_allow(path_ctl_allow), .conn_state(conn_state), .flipped(flipped),
		.vbus_on(vbus_on), .vconn_cc1_on(vconn_cc1_on), .vconn_cc2_on(vconn_cc2_on),
		.pullup_on(pullup_on), .pullup_level(pullup_level), .pulldown_on(pulldown_on),
		.deadbat_gate_oe(deadbat_gate_oe), .swap_pulldown_cc1(swap_pulldown_cc1),
		.swap_pulldown_cc2(swap_pulldown_cc2), .swap_detected(swap_detected),
		.partner_adv(partner_adv), .ext_path_ctl(ext_path_ctl), .source_active(source_active));

	cc_partner_model u_cc_partner_model (.swap_pulldown_cc1(swap_pulldown_cc1),
		.swap_pulldown_cc2(swap_pulldown_cc2), .term1(term1), .term2(term2),
		.src_mode(src_mode), .src_code(src_code), .frs_low(frs_low),
		.cc1_level(cc1_level), .cc2_level(cc2_level));

	task automatic finish_test;
		$display("comparisons %0d, errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test

	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask : check

	// bounded wait on the connection state; running out ends the run
	task automatic wait_conn(input logic [2:0] exp);
		int n = 0;
		while (conn_state !== exp && n < 60)
		begin
			@(negedge clk);
			n++;
		end
		check("conn_state", {5'h00, exp}, {5'h00, conn_state});
		// a timeout has just been counted as a mismatch
		if (conn_state !== exp)
			finish_test();
	endtask : wait_conn

	// latency of a line change is sync plus debounce plus two registers
	task automatic settle;
		repeat (SETTLE) @(negedge clk);
	endtask : settle

	task automatic do_reset(input logic [1:0] role);
		@(posedge clk);
		reset_n <= 1'b0;
		role_sel <= role;
		{term1, term2, src_mode, frs_low, swap_enable, swap_request} <= '0;
		{vbus_present, dead_battery, ovp_uvp, path_ctl_allow, clk_en} <= 5'h01;
		repeat (8) @(posedge clk);
		check("vbus_on in reset", 8'h00, {7'h00, vbus_on});
		check("pullup_on in reset", 8'h00, {7'h00, pullup_on});
		reset_n <= 1'b1;
		settle();
	endtask : do_reset

	// every source-side termination pair except open cc1 with cable cc2, each followed by a detach
	task automatic t_source_table;
		logic [10:0] r;
		do_reset(ROLE_SOURCE);
		check("pullup_on", 8'h01, {7'h00, pullup_on});
		check("vbus idle", 8'h00, {7'h00, vbus_on | vconn_cc1_on | vconn_cc2_on});
		for (int i = 0; i < 7; i++)
		begin
			r = src_table[i];
			@(posedge clk);
			term1 <= r[10:9];
			term2 <= r[8:7];
			wait_conn(r[6:4]);
			// orientation is registered one cycle after the state
			@(negedge clk);
			if (r[6:4] == ST_SINK || r[6:4] == ST_CABLE_SINK)
				check("flipped", {7'h00, r[3]}, {7'h00, flipped});
			if (r[6:4] < 3'h4)
				check("power", {5'h00, r[2:0]}, {5'h00, vbus_on, vconn_cc1_on, vconn_cc2_on});
			@(posedge clk);
			{term1, term2} <= 4'h0;
			wait_conn(ST_OPEN);
			check("power off", 8'h00, {5'h00, vbus_on, vconn_cc1_on, vconn_cc2_on});
		end
	endtask : t_source_table

	// a weak sink sits above the lowest level's threshold only
	task automatic t_adv_levels;
		for (int lvl = 0; lvl < 4; lvl++)
		begin
			@(posedge clk);
			adv_level <= lvl[1:0];
			term1 <= 2'h3;
			settle();
			check("pullup_level", lvl[7:0], {6'h00, pullup_level});
			check("weak sink", (lvl == 0) ? 8'h00 : 8'h03, {5'h00, conn_state});
			@(posedge clk);
			term1 <= 2'h0;
			wait_conn(ST_OPEN);
		end
	endtask : t_adv_levels

	// sink role: attach only with vbus, decode partner pull-up, then swap
	task automatic t_sink;
		int pulses = 0;
		do_reset(ROLE_SINK);
		check("pulldown", 8'h02, {6'h00, pulldown_on, pullup_on});
		@(posedge clk);
		{src_mode, swap_enable} <= 2'h3;
		settle();
		check("no vbus no attach", 8'h00, {5'h00, conn_state});
		@(posedge clk);
		vbus_present <= 1'b1;
		wait_conn(ST_SRC_SEEN);
		check("partner_adv def", {6'h00, ADV_DEF500}, {6'h00, partner_adv});
		@(posedge clk);
		src_code <= 8'hA0;
		settle();
		check("partner_adv 1a5", {6'h00, ADV_1A5}, {6'h00, partner_adv});
		@(posedge clk);
		src_code <= 8'hE0;
		settle();
		check("partner_adv 3a0", {6'h00, ADV_3A0}, {6'h00, partner_adv});
		check("source_active", 8'h00, {7'h00, source_active});
		@(posedge clk);
		frs_low <= 1'b1;
		repeat (40) @(negedge clk) pulses += swap_detected;
		check("swap pulses", 8'h01, pulses[7:0]);
		check("source after swap", 8'h01, {7'h00, source_active});
	endtask : t_sink

	// ovp and a frozen clock enable, then source swap and dead battery
	task automatic t_source_misc;
		do_reset(ROLE_SOURCE);
		@(posedge clk);
		{term1, vbus_present, path_ctl_allow, swap_enable} <= 5'h0F;
		wait_conn(ST_SINK);
		check("ext path", 8'h01, {7'h00, ext_path_ctl});
		@(posedge clk);
		ovp_uvp <= 1'b1;
		settle();
		check("ext path ovp", 8'h00, {7'h00, ext_path_ctl});
		@(posedge clk);
		{ovp_uvp, clk_en, term1} <= 4'h0;
		settle();
		check("frozen", {5'h00, ST_SINK}, {5'h00, conn_state});
		@(posedge clk);
		{clk_en, term1, swap_request} <= 4'hB;
		settle();
		check("swap pulldown", 8'h02, {6'h00, swap_pulldown_cc1, swap_pulldown_cc2});
		@(posedge clk);
		vbus_present <= 1'b0;
		settle();
		check("sink after swap", 8'h00, {7'h00, source_active});
		do_reset(ROLE_SOURCE);
		@(posedge clk);
		dead_battery <= 1'b1;
		settle();
		check("deadbat hi-z", 8'h00, {7'h00, deadbat_gate_oe});
	endtask : t_source_misc

	// dual role alternates its terminations while nothing is attached
	task automatic t_dual;
		int flips = 0;
		logic last;
		do_reset(ROLE_DUAL);
		last = pullup_on;
		repeat (60)
		begin
			@(negedge clk);
			flips += (pullup_on !== last);
			last = pullup_on;
		end
		check("dual toggles", 8'h01, {7'h00, flips >= 4});
		check("dual exclusive", 8'h01, {7'h00, pullup_on ^ pulldown_on});
	endtask : t_dual

	initial
	begin
		t_source_table();
		t_adv_levels();
		t_sink();
		t_source_misc();
		t_dual();
		finish_test();
	end
endmodule : cc_attach_port_test
